// [core/otp_prog_defines.svh]
// Constants for the parallel programming port: mode codes, timing, sizes
`ifndef OTP_PROG_DEFINES_SVH
`define OTP_PROG_DEFINES_SVH

`define CODE_ADDR_BITS      14
`define KEY_ADDR_BITS       6
`define KEY_LAST_ADDR       16'h001F
`define PULSES_PER_WRITE    3'd5
`define CLK_PERIOD_NS       10
`define PULSE_LOW_US        100
`define PULSE_TOL_US        10
`define PULSE_HIGH_MIN_US   10
`define PULSE_LOW_CYCLES    ((`PULSE_LOW_US * 1000) / `CLK_PERIOD_NS)
`define PULSE_HIGH_CYCLES   (((`PULSE_HIGH_MIN_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYCLES        48
`define SIG_ADDR_0          16'h0030
`define SIG_ADDR_1          16'h0031
`define SIG_ADDR_2          16'h0060
// Selector codes {p2_7, p2_6, p3_7, p3_6}
`define SEL_SIGNATURE       4'h0
`define SEL_CODE            4'hB
`define SEL_VERIFY          4'h3
`define SEL_KEY             4'hA
`define SEL_SEC1            4'hF
`define SEL_SEC2            4'hC
`define SEL_SEC3            4'h5
`define SEL_VERIFY_SEC      4'h2
`define SEC1_OUT_BIT        7
`define SEC2_OUT_BIT        6
`define SEC3_OUT_BIT        3
`define ERASED_BYTE         8'hFF

`endif

// [core/otp_prog_pkg.sv]
// Types shared by both ends of the programming port
package otp_prog_pkg;
	typedef enum logic [2:0] {
		op_none      = 3'b000,
		op_code      = 3'b001,
		op_key       = 3'b010,
		op_sec1      = 3'b011,
		op_sec2      = 3'b100,
		op_sec3      = 3'b101,
		op_verify    = 3'b110,
		op_signature = 3'b111
	} op_type;
endpackage

// [core/otp_prog_if.sv]
// Pin-level link between the programmer and the device
`timescale 1ns/1ns
`default_nettype none
interface otp_prog_if;
	logic       rst_pin;
	logic       code_fetch_strobe_pin;
	logic       program_strobe_pin;
	logic       program_voltage_pin;
	logic [7:0] p1;
	logic [7:0] p2;
	logic [7:0] p3;
	logic [7:0] p0_to_dev;
	logic [7:0] p0_from_dev;
	logic       p0_dev_oe;

	modport device (
		input  rst_pin, code_fetch_strobe_pin, program_strobe_pin, program_voltage_pin,
		input  p1, p2, p3, p0_to_dev,
		output p0_from_dev, p0_dev_oe
	);
	modport programmer (
		output rst_pin, code_fetch_strobe_pin, program_strobe_pin, program_voltage_pin,
		output p1, p2, p3, p0_to_dev,
		input  p0_from_dev, p0_dev_oe
	);
endinterface
`default_nettype wire

// [core/otp_prog_device.sv]
// Device end: pin sampling, five-pulse write engine, lockouts, verify
`timescale 1ns/1ns
`default_nettype none
`include "otp_prog_defines.svh"

// Functional notes
// - Programmer keeps device clock at 4-6 MHz (timing here assumes a 10 ns, 100 MHz clock)
// - Programmer holds address on ports 1, 2
// - Programmer drives write data on port 0
// - Programmer holds code-write control pin levels
// - Five low strobe pulses per location
// - Key table written at addresses 0..1FH
// - Verify returns encrypted data once key written
// - Security bit set by same five pulses
// - Any security bit locks code and key
// - Unset security bits stay programmable
// - Three readable identification bytes
// - Strobe low 100us +-10, high >=10us
// - Verify output is XNOR of code and key
module otp_prog_device #(
	parameter logic [7:0] MAKER_ID  = 8'h5A, // Arbitrary value
	parameter logic [7:0] PART_ID   = 8'hC3, // Arbitrary value
	parameter logic [7:0] PART_ID_2 = 8'h01  // Arbitrary value
) (
	input  wire logic   mclk,
	input  wire logic   rst,
	otp_prog_if.device  pins,
	output logic [2:0]  security_bits,
	output logic        key_written,
	output logic        write_error
);
	import otp_prog_pkg::*;

	logic [7:0] code_mem [0:(1 << `CODE_ADDR_BITS) - 1];
	logic [7:0] key_mem  [0:(1 << `KEY_ADDR_BITS) - 1];

	//////////////////////////////////////////////////////////////////////
	// Three-stage synchronisers; a change counts once stages 2 and 3 agree
	localparam int SYNC_W = 1 + 1 + 1 + 1 + 8 + 8 + 8 + 8;
	// All stages start at idle levels, so reset shows no false strobe edge
	localparam logic [SYNC_W-1:0] SYNC_IDLE = {2'b01, 1'b1, 1'b0, 32'h0000_0000};
	logic [SYNC_W-1:0] raw_in;
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic [SYNC_W-1:0] sync3;
	logic [SYNC_W-1:0] stable;

	assign raw_in = {pins.rst_pin, pins.code_fetch_strobe_pin, pins.program_strobe_pin,
		pins.program_voltage_pin, pins.p1, pins.p2, pins.p3, pins.p0_to_dev};

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
			sync3 <= SYNC_IDLE;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stable <= SYNC_IDLE;
		end else begin
			for (int i = 0; i < SYNC_W; i++) begin
				if (sync2[i] == sync3[i])
					stable[i] <= sync3[i];
			end
		end
	end

	logic        s_rst;
	logic        s_fetch;
	logic        s_strobe;
	logic        s_vpp;
	logic [7:0]  s_p1;
	logic [7:0]  s_p2;
	logic [7:0]  s_p3;
	logic [7:0]  s_p0;
	logic [15:0] s_addr;
	logic [3:0]  s_sel;
	op_type      s_op;

	assign {s_rst, s_fetch, s_strobe, s_vpp, s_p1, s_p2, s_p3, s_p0} = stable;
	assign s_addr = {s_p2, s_p1};
	assign s_sel  = {s_p2[7], s_p2[6], s_p3[7], s_p3[6]};

	function automatic op_type decode_op(input logic [3:0] sel, input logic prog);
		if (prog) begin
			case (sel)
				`SEL_CODE: decode_op = op_code;
				`SEL_KEY:  decode_op = op_key;
				`SEL_SEC1: decode_op = op_sec1;
				`SEL_SEC2: decode_op = op_sec2;
				`SEL_SEC3: decode_op = op_sec3;
				default:   decode_op = op_none;
			endcase
		end else begin
			case (sel)
				`SEL_VERIFY:     decode_op = op_verify;
				`SEL_VERIFY_SEC: decode_op = op_verify;
				`SEL_SIGNATURE:  decode_op = op_signature;
				default:         decode_op = op_none;
			endcase
		end
	endfunction

	assign s_op = (s_rst && !s_fetch) ? decode_op(s_sel, s_vpp) : op_none;

	//////////////////////////////////////////////////////////////////////
	// Pulse counter: a train ends when the operation, address or data change
	logic [2:0]  pulse_count;
	logic        strobe_prev;
	op_type      train_op;
	logic [15:0] train_addr;
	logic [7:0]  train_data;
	logic        train_broken;
	logic        pulse_end;

	assign pulse_end = !strobe_prev && s_strobe; // Rising edge ends one pulse
	assign train_broken = (pulse_count != 3'd0) &&
		(s_op != train_op || s_addr != train_addr || s_p0 != train_data);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			strobe_prev <= 1'b1;
		else
			strobe_prev <= s_strobe;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pulse_count <= 3'd0;
			train_op    <= op_none;
			train_addr  <= 16'h0000;
			train_data  <= 8'h00;
		end else if (train_broken || s_op == op_none || s_op == op_verify ||
				s_op == op_signature) begin
			pulse_count <= 3'd0;
		end else if (pulse_end) begin
			train_op    <= s_op;
			train_addr  <= s_addr;
			train_data  <= s_p0;
			pulse_count <= (pulse_count == `PULSES_PER_WRITE - 3'd1) ? 3'd0
				: pulse_count + 3'd1;
		end
	end

	logic commit;
	assign commit = pulse_end && !train_broken && s_op != op_none &&
		s_op != op_verify && s_op != op_signature &&
		pulse_count == `PULSES_PER_WRITE - 3'd1;

	//////////////////////////////////////////////////////////////////////
	// Storage and lockouts
	logic                             locked;
	logic                             key_wr;
	logic [(1 << `KEY_ADDR_BITS)-1:0] key_set;
	assign locked = |security_bits;
	// Selector bits sit above the address, so only address bits are compared
	assign key_wr = commit && s_op == op_key && !locked &&
		{2'b00, s_addr[`CODE_ADDR_BITS-1:0]} <= `KEY_LAST_ADDR;

	always_ff @(posedge mclk) begin
		if (commit && s_op == op_code && !locked)
			code_mem[s_addr[`CODE_ADDR_BITS-1:0]] <= s_p0;
		if (key_wr)
			key_mem[s_addr[`KEY_ADDR_BITS-1:0]] <= s_p0;
	end

	// Table bytes never written read as erased ones, not as unknowns
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			key_set <= '0;
		else if (key_wr)
			key_set[s_addr[`KEY_ADDR_BITS-1:0]] <= 1'b1;
	end

	// Fuse-like state; volatile here, so reset stands for a blank part
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			security_bits <= 3'b000;
			key_written   <= 1'b0;
			write_error   <= 1'b0;
		end else if (commit) begin
			case (s_op)
				op_key: begin
					if (!locked)
						key_written <= 1'b1;
				end
				op_sec1: security_bits[0] <= 1'b1;
				op_sec2: security_bits[1] <= 1'b1;
				op_sec3: security_bits[2] <= 1'b1;
				default: ;
			endcase
			write_error <= locked && (s_op == op_code || s_op == op_key);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Read path: verify, security readback, identification
	function automatic logic [7:0] encrypt(input logic [7:0] code, input logic [7:0] key);
		encrypt = ~(code ^ key);
	endfunction

	logic [7:0] code_rd;
	logic [7:0] key_rd;
	logic [7:0] next_out;
	logic       next_oe;

	always_ff @(posedge mclk) begin
		code_rd <= code_mem[s_addr[`CODE_ADDR_BITS-1:0]];
		key_rd  <= key_set[s_addr[`KEY_ADDR_BITS-1:0]] ? key_mem[s_addr[`KEY_ADDR_BITS-1:0]]
			: `ERASED_BYTE;
	end

	always_comb begin
		next_out = 8'h00;
		next_oe  = 1'b0;
		case (s_op)
			op_verify: begin
				if (s_sel == `SEL_VERIFY_SEC) begin
					next_oe = 1'b1;
					next_out[`SEC1_OUT_BIT] = security_bits[0];
					next_out[`SEC2_OUT_BIT] = security_bits[1];
					next_out[`SEC3_OUT_BIT] = security_bits[2];
				end else if (!security_bits[1]) begin
					next_oe  = 1'b1;
					// Once a key exists bytes leave XNORed with the key; unwritten key bytes read FF, so those leave raw
					next_out = key_written ? encrypt(code_rd, key_rd) : code_rd;
				end
			end
			op_signature: begin
				next_oe = 1'b1;
				case (s_addr)
					`SIG_ADDR_0: next_out = MAKER_ID;
					`SIG_ADDR_1: next_out = PART_ID;
					`SIG_ADDR_2: next_out = PART_ID_2;
					default:     next_out = 8'h00;
				endcase
			end
			default: ;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pins.p0_from_dev <= 8'h00;
			pins.p0_dev_oe   <= 1'b0;
		end else begin
			pins.p0_from_dev <= next_out;
			pins.p0_dev_oe   <= next_oe;
		end
	end
endmodule
`default_nettype wire

// [core/otp_prog_programmer.sv]
// Programmer end: drives mode pins and the five-pulse strobe train
`timescale 1ns/1ns
`default_nettype none
`include "otp_prog_defines.svh"

module otp_prog_programmer (
	input  wire logic        mclk,
	input  wire logic        rst,
	otp_prog_if.programmer   pins,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire otp_prog_pkg::op_type req_op,
	input  wire logic [15:0] req_addr,
	input  wire logic [7:0]  req_data,
	output logic             done,
	output logic [7:0]       read_data
);
	import otp_prog_pkg::*;

	typedef enum logic [2:0] {
		st_idle   = 3'b000,
		st_setup  = 3'b001,
		st_low    = 3'b010,
		st_high   = 3'b011,
		st_hold   = 3'b100,
		st_sample = 3'b101
	} state_type;

	// Low time sits on the nominal 100us, inside the +-10us band
	localparam int SETUP_CNT = `SETUP_CYCLES * 4 + 16; // Device clock runs slower
	state_type   state;
	op_type      op;
	logic [15:0] addr;
	logic [7:0]  data;
	logic [2:0]  pulses;
	logic [15:0] timer;
	logic        strobe;

	function automatic logic [3:0] sel_of(input op_type o);
		case (o)
			op_code:      sel_of = `SEL_CODE;
			op_key:       sel_of = `SEL_KEY;
			op_sec1:      sel_of = `SEL_SEC1;
			op_sec2:      sel_of = `SEL_SEC2;
			op_sec3:      sel_of = `SEL_SEC3;
			op_signature: sel_of = `SEL_SIGNATURE;
			default:      sel_of = `SEL_VERIFY;
		endcase
	endfunction

	logic is_write;
	assign is_write  = op inside {op_code, op_key, op_sec1, op_sec2, op_sec3};
	assign req_ready = (state == st_idle);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state     <= st_idle;
			op        <= op_none;
			addr      <= 16'h0000;
			data      <= 8'h00;
			pulses    <= 3'd0;
			timer     <= 16'h0000;
			strobe    <= 1'b1;
			done      <= 1'b0;
			read_data <= 8'h00;
		end else begin
			done <= 1'b0;
			case (state)
				st_idle: begin
					if (req_valid) begin
						op     <= req_op;
						addr   <= req_addr;
						data   <= req_data;
						pulses <= 3'd0;
						timer  <= 16'(SETUP_CNT);
						state  <= st_setup;
					end
				end
				st_setup: begin
					if (timer != 16'h0000)
						timer <= timer - 16'h0001;
					else if (is_write) begin
						strobe <= 1'b0;
						timer  <= 16'(`PULSE_LOW_CYCLES - 1);
						state  <= st_low;
					end else
						state <= st_sample;
				end
				st_low: begin
					if (timer != 16'h0000)
						timer <= timer - 16'h0001;
					else begin
						strobe <= 1'b1;
						pulses <= pulses + 3'd1;
						timer  <= 16'(`PULSE_HIGH_CYCLES - 1);
						state  <= (pulses == `PULSES_PER_WRITE - 3'd1) ? st_hold : st_high;
					end
				end
				st_high: begin
					if (timer != 16'h0000)
						timer <= timer - 16'h0001;
					else begin
						strobe <= 1'b0;
						timer  <= 16'(`PULSE_LOW_CYCLES - 1);
						state  <= st_low;
					end
				end
				st_hold: begin
					if (timer != 16'h0000)
						timer <= timer - 16'h0001;
					else begin
						done  <= 1'b1;
						state <= st_idle;
					end
				end
				st_sample: begin
					read_data <= pins.p0_from_dev;
					done      <= 1'b1;
					state     <= st_idle;
				end
				default: state <= st_idle;
			endcase
		end
	end

	// Pin levels hold the selected mode for the whole operation
	logic [3:0] sel;
	assign sel = sel_of(op);
	assign pins.rst_pin               = (state != st_idle);
	assign pins.code_fetch_strobe_pin = 1'b0;
	assign pins.program_strobe_pin    = strobe;
	assign pins.program_voltage_pin   = (state != st_idle) && is_write;
	assign pins.p1        = addr[7:0];
	assign pins.p2        = {sel[3], sel[2], addr[13:8]};
	assign pins.p3        = {sel[1], sel[0], 6'h00};
	assign pins.p0_to_dev = data;
endmodule
`default_nettype wire

// [tb/otp_prog_asserts.sv]
// Pin protocol checker for the programming port link
`timescale 1ns/1ns
`default_nettype none
module otp_prog_asserts #(
	parameter logic [7:0] MAKER_ID = 8'h00
) (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       rst_pin,
	input wire logic       code_fetch_strobe_pin,
	input wire logic       program_strobe_pin,
	input wire logic       program_voltage_pin,
	input wire logic [7:0] p1,
	input wire logic [7:0] p2,
	input wire logic [7:0] p3,
	input wire logic [7:0] p0_to_dev,
	input wire logic [7:0] p0_from_dev,
	input wire logic       p0_dev_oe
);
	localparam logic [15:0] LOW_MIN  = 16'h2328;
	localparam logic [15:0] LOW_MAX  = 16'h2AF8;
	localparam logic [15:0] HIGH_MIN = 16'h03E8;
	logic [15:0] low_cnt;
	logic [15:0] high_cnt;
	logic [3:0]  pulse_cnt;
	logic        sig_pins;
	logic        verify_pins;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// High count saturates so the first pulse after reset passes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			low_cnt <= 16'h0000;
			high_cnt <= 16'hFFFF;
		end else if (program_strobe_pin) begin
			low_cnt <= 16'h0000;
			high_cnt <= high_cnt + {15'h0000, high_cnt != 16'hFFFF};
		end else begin
			low_cnt <= low_cnt + 16'h0001;
			high_cnt <= 16'h0000;
		end
	end
	// Pulses counted per stable address, data and mode
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			pulse_cnt <= 4'h0;
		else if (!program_voltage_pin || !$stable({p1, p2, p3, p0_to_dev}))
			pulse_cnt <= 4'h0;
		else if ($fell(program_strobe_pin))
			pulse_cnt <= pulse_cnt + 4'h1;
	end
	assign sig_pins = rst_pin && program_strobe_pin && !program_voltage_pin
		&& p2 == 8'h00 && p1 == 8'h30 && p3[7:6] == 2'b00;
	assign verify_pins = rst_pin && program_strobe_pin && !program_voltage_pin
		&& p2[7:6] == 2'b00 && p3[7:6] == 2'b11;
	////////////////////////////////////////////////////////////////
	property p_low_width;
		$rose(program_strobe_pin) |-> low_cnt >= LOW_MIN && low_cnt <= LOW_MAX;
	endproperty
	a_low_width: assert property (p_low_width)
		else $error("strobe low time out of range");
	property p_high_gap;
		$fell(program_strobe_pin) |-> high_cnt >= HIGH_MIN;
	endproperty
	a_high_gap: assert property (p_high_gap)
		else $error("strobe high gap too short");
	property p_hold_stable;
		!program_strobe_pin && !$past(program_strobe_pin) |->
			$stable(p1) && $stable(p2) && $stable(p3) && $stable(p0_to_dev);
	endproperty
	a_hold_stable: assert property (p_hold_stable)
		else $error("address or data moved during pulse");
	property p_mode_levels;
		!program_strobe_pin |-> program_voltage_pin && rst_pin && !code_fetch_strobe_pin;
	endproperty
	a_mode_levels: assert property (p_mode_levels)
		else $error("control levels wrong during pulse");
	property p_no_contention;
		!program_strobe_pin |-> !p0_dev_oe;
	endproperty
	a_no_contention: assert property (p_no_contention)
		else $error("device drives data lines during write");
	property p_five_pulses;
		!$stable({p1, p2, p3, p0_to_dev}) || $fell(program_voltage_pin) |->
			pulse_cnt == 4'h0 || pulse_cnt == 4'h5;
	endproperty
	a_five_pulses: assert property (p_five_pulses)
		else $error("pulse train not five pulses");
	property p_sig_answer;
		sig_pins [*8] |-> p0_dev_oe && p0_from_dev == MAKER_ID;
	endproperty
	a_sig_answer: assert property (p_sig_answer)
		else $error("maker byte not presented");
	property p_verify_drive;
		verify_pins [*8] |-> p0_dev_oe;
	endproperty
	a_verify_drive: assert property (p_verify_drive)
		else $error("verify data not driven");
endmodule
`default_nettype wire

// [tb/otp_parallel_program_port_tb.sv]
// Bench joining the programmer end to the device end
`timescale 1ns/1ns
`default_nettype none
`define check_eq(got, exp) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		err_count++; \
		$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
	end \
end
module otp_parallel_program_port_tb;
	import otp_prog_pkg::*;
	localparam logic [7:0] MAKER    = 8'h6B; // Arbitrary value
	localparam logic [7:0] PART     = 8'h4D; // Arbitrary value
	localparam logic [7:0] PART_2   = 8'h17; // Arbitrary value
	localparam int         WAIT_MAX = 60000;
	logic        mclk;
	logic        rst;
	logic        req_valid;
	logic        req_ready;
	op_type      req_op;
	logic [15:0] req_addr;
	logic [7:0]  req_data;
	logic        done;
	logic [7:0]  read_data;
	logic [2:0]  security_bits;
	logic        key_written;
	logic        write_error;
	logic [7:0]  rd;
	int          err_count;
	int          n_tests;
	otp_prog_if link();
	otp_prog_programmer otp_prog_programmer_i (.mclk(mclk), .rst(rst), .pins(link),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
		.req_data(req_data), .done(done), .read_data(read_data));
	otp_prog_device #(.MAKER_ID(MAKER), .PART_ID(PART), .PART_ID_2(PART_2)) otp_prog_device_i (
		.mclk(mclk), .rst(rst), .pins(link), .security_bits(security_bits),
		.key_written(key_written), .write_error(write_error));
	otp_prog_asserts #(.MAKER_ID(MAKER)) otp_prog_asserts_i (.mclk(mclk), .rst(rst),
		.rst_pin(link.rst_pin), .code_fetch_strobe_pin(link.code_fetch_strobe_pin),
		.program_strobe_pin(link.program_strobe_pin),
		.program_voltage_pin(link.program_voltage_pin), .p1(link.p1), .p2(link.p2),
		.p3(link.p3), .p0_to_dev(link.p0_to_dev), .p0_from_dev(link.p0_from_dev),
		.p0_dev_oe(link.p0_dev_oe));
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Request is held until ready, then the done pulse is awaited
	task automatic do_op(input op_type op, input logic [15:0] addr, input logic [7:0] data);
		int n;
		n = 0;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= addr;
		req_data <= data;
		do begin
			@(negedge mclk);
			n++;
		end while (req_ready !== 1'b1 && n < WAIT_MAX);
		@(posedge mclk);
		req_valid <= 1'b0;
		do begin
			@(negedge mclk);
			n++;
		end while (done !== 1'b1 && n < WAIT_MAX);
		rd = read_data;
		if (done !== 1'b1) begin
			`check_eq(done, 1'b1)
			tally_and_finish();
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_code_write;
		do_op(op_code, 16'h0005, 8'hA5);
		`check_eq(write_error, 1'b0)
		do_op(op_verify, 16'h0005, 8'h00);
		`check_eq(rd, 8'hA5)
		$display("test code write done");
	endtask
	task automatic t_key;
		do_op(op_key, 16'h0005, 8'h3C);
		`check_eq(key_written, 1'b1)
		do_op(op_verify, 16'h0005, 8'h00);
		`check_eq(rd, ~(8'hA5 ^ 8'h3C))
		$display("test key table done");
	endtask
	task automatic t_signature;
		logic [15:0] a [3] = '{16'h0030, 16'h0031, 16'h0060};
		logic [7:0]  e [3] = '{MAKER, PART, PART_2};
		for (int i = 0; i < 3; i++) begin
			do_op(op_signature, a[i], 8'h00);
			`check_eq(rd, e[i])
		end
		$display("test signature done");
	endtask
	// Lock first, then a refused code write must leave the byte alone
	task automatic t_lock;
		do_op(op_sec1, 16'h0000, 8'h00);
		`check_eq(security_bits, 3'b001)
		do_op(op_code, 16'h0005, 8'h00);
		`check_eq(write_error, 1'b1)
		do_op(op_verify, 16'h0005, 8'h00);
		`check_eq(rd, ~(8'hA5 ^ 8'h3C))
		do_op(op_sec3, 16'h0000, 8'h00);
		`check_eq(security_bits, 3'b101)
		$display("test lockout done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_op = op_none;
		req_addr = 16'h0000;
		req_data = 8'h00;
		err_count = 0;
		n_tests = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		t_code_write();
		t_key();
		t_signature();
		t_lock();
		tally_and_finish();
	end
endmodule
`default_nettype wire
